// *** hdl/emccd_line_pkg.sv ***
// Constants for the multiplying-register line bookkeeping block.
// Assumes one 250 MHz clock; timing figures are in ns where so named, else counts of that clock or of
// horizontal clock cycles.
package emccd_line_pkg;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 4;
  // Shortest legal pixel period in ns
  localparam int PIXEL_MIN_NS = 50;
  // Shortest pixel period in clocks, rounded up
  localparam int PIXEL_MIN_CYC = (PIXEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Horizontal counter width
  localparam int HCNT_W = 12;
  // Line counter width
  localparam int LINE_W = 16;
  // Multiplying transfers per quadrant
  localparam logic [10:0] MULT_STAGES = 11'h708;
  // First active pixel at the threshold-sense output
  localparam logic [HCNT_W-1:0] TS_FIRST = 12'h024;
  // First active pixel at the normal-gain output
  localparam logic [HCNT_W-1:0] NG_FIRST = 12'h044;
  // First active pixel at the multiplied output
  localparam logic [HCNT_W-1:0] MU_FIRST = 12'h040;
  // Horizontal cycles per line, whole line to one side
  localparam logic [HCNT_W-1:0] NH_WHOLE = 12'hc0c;
  // Horizontal cycles per line, line split left and right
  localparam logic [HCNT_W-1:0] NH_SPLIT = 12'h606;
  // Line lag of the multiplied output in each mode
  localparam logic [LINE_W-1:0] LAG_WHOLE = 16'h0001;
  localparam logic [LINE_W-1:0] LAG_SPLIT = 16'h0002;
  // Binning codes
  typedef enum logic [1:0] {BIN_1X1, BIN_2X2, BIN_3X3, BIN_4X4} bin_mode_t;
  // Number of synchronised pins
  localparam int PIN_W = 7;
endpackage

// *** hdl/emccd_line_tracker.sv ***
// Horizontal readout bookkeeping of one quadrant's multiplying register.
// Assumes all clock pins arrive asynchronously from the camera timing generator.
`timescale 1ns/100ps
module emccd_line_tracker (
  input wire logic i_ref_clk, // 250 MHz clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_last_horizontal_gate_clock, // Last gate clock pin
  input wire logic i_line_start, // Row transfer done, line begins
  input wire logic i_split_mode, // High: line split left and right
  input wire logic i_mult_barrier_phase2, // Second barrier clock pin
  input wire logic i_mult_storage_phase2, // Second storage clock pin
  input wire logic [1:0] i_bin_mode, // Binning setting
  output logic o_threshold_first, // Pulse: first pixel at sense output
  output logic o_normal_first, // Pulse: first pixel at normal output
  output logic o_multiplied_first, // Pulse: first pixel at multiplied output
  output logic o_pixel_valid, // Pulse: one binned pixel out
  output logic [emccd_line_pkg::LINE_W-1:0] o_normal_line, // Line now at normal output
  output logic [emccd_line_pkg::LINE_W-1:0] o_multiplied_line, // Line at multiplied output
  output logic [emccd_line_pkg::HCNT_W+1:0] o_column_index, // Sensor columns consumed
  output logic [10:0] o_mult_step, // Multiplying step index
  output logic o_mult_pass, // Pulse: a full pass of the register
  output logic o_line_len_error, // Sticky: wrong line length
  output logic o_pixel_short, // Sticky: pixel period too short
  output logic o_barrier_order_error // Sticky: barrier edge out of order
);
  import emccd_line_pkg::*;

  logic [PIN_W-1:0] lvl; // Settled pins
  logic lg_q, ls_q, b2_q, s2_q; // Previous settled levels
  logic [HCNT_W-1:0] hcnt, next_hcnt; // Horizontal cycles in line
  logic [7:0] gap, next_gap; // Clocks since last pixel
  logic [LINE_W-1:0] next_normal_line, next_mult_line;
  logic [HCNT_W+1:0] next_col;
  logic [10:0] next_step;
  logic next_ts, next_ng, next_mu, next_pv, next_pass;
  logic next_len_err, next_short, next_order_err;
  logic lg_fall, ls_rise, b2_rise, s2_fall; // Events
  logic split; // Settled split mode
  bin_mode_t bin; // Settled binning

  // Pin synchroniser for every asynchronous input
  pin_sync #(.WIDTH(PIN_W)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin({i_bin_mode, i_mult_storage_phase2, i_mult_barrier_phase2,
            i_split_mode, i_line_start, i_last_horizontal_gate_clock}),
    .o_level(lvl)
  );

  // Columns per binned pixel
  function automatic logic [2:0] bin_factor(input bin_mode_t m);
    return 3'(m) + 3'h1;
  endfunction

  // Edge events on settled levels
  always_comb begin
    lg_fall = lg_q && !lvl[0]; // Charge moves on the falling gate edge
    ls_rise = !ls_q && lvl[1];
    split = lvl[2];
    b2_rise = !b2_q && lvl[3];
    s2_fall = s2_q && !lvl[4];
    bin = bin_mode_t'(lvl[6:5]);
  end

  // Next-state computation
  always_comb begin
    next_hcnt = hcnt;
    next_gap = (gap == 8'hff) ? gap : gap + 8'h01;
    next_normal_line = o_normal_line;
    next_step = o_mult_step;
    next_len_err = o_line_len_error;
    next_short = o_pixel_short;
    next_order_err = o_barrier_order_error;
    next_pass = 1'b0;
    next_pv = 1'b0;
    if (ls_rise) begin
      // Line length check on the line just finished
      if (o_normal_line != '0 && hcnt != (split ? NH_SPLIT : NH_WHOLE)) begin
        next_len_err = 1'b1;
      end
      next_hcnt = '0;
      next_normal_line = o_normal_line + 16'h0001;
    end else if (lg_fall) begin
      next_hcnt = hcnt + 12'h001;
      next_pv = 1'b1;
      next_gap = 8'h00;
      if (gap < 8'(PIXEL_MIN_CYC - 1)) begin
        next_short = 1'b1;
      end
    end
    // Arrival of the first active pixel at each output
    next_ts = lg_fall && !ls_rise && (next_hcnt == TS_FIRST);
    next_ng = lg_fall && !ls_rise && (next_hcnt == NG_FIRST);
    next_mu = lg_fall && !ls_rise && (next_hcnt == MU_FIRST);
    // Multiplied output trails by a fixed number of lines
    next_mult_line = next_normal_line - (split ? LAG_SPLIT : LAG_WHOLE);
    // Binned pixels come out at one per cycle whatever the setting
    next_col = {2'b00, next_hcnt} * {11'h000, bin_factor(bin)};
    // One multiplying step per barrier rise; a rise with storage low still steps and sets the order error
    if (b2_rise) begin
      if (!lvl[4]) begin
        next_order_err = 1'b1;
      end
      if (o_mult_step == MULT_STAGES - 11'h001) begin
        next_step = '0;
        next_pass = 1'b1;
      end else begin
        next_step = o_mult_step + 11'h001;
      end
    end
    if (s2_fall && lvl[3]) begin
      next_order_err = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lg_q <= 1'b0;
      ls_q <= 1'b0;
      b2_q <= 1'b0;
      s2_q <= 1'b0;
      hcnt <= '0;
      gap <= 8'hff;
      o_normal_line <= '0;
      o_multiplied_line <= '0;
      o_column_index <= '0;
      o_mult_step <= '0;
      o_mult_pass <= 1'b0;
      o_threshold_first <= 1'b0;
      o_normal_first <= 1'b0;
      o_multiplied_first <= 1'b0;
      o_pixel_valid <= 1'b0;
      o_line_len_error <= 1'b0;
      o_pixel_short <= 1'b0;
      o_barrier_order_error <= 1'b0;
    end else begin
      lg_q <= lvl[0];
      ls_q <= lvl[1];
      b2_q <= lvl[3];
      s2_q <= lvl[4];
      hcnt <= next_hcnt;
      gap <= next_gap;
      o_normal_line <= next_normal_line;
      o_multiplied_line <= next_mult_line;
      o_column_index <= next_col;
      o_mult_step <= next_step;
      o_mult_pass <= next_pass;
      o_threshold_first <= next_ts;
      o_normal_first <= next_ng;
      o_multiplied_first <= next_mu;
      o_pixel_valid <= next_pv;
      o_line_len_error <= next_len_err;
      o_pixel_short <= next_short;
      o_barrier_order_error <= next_order_err;
    end
  end

  // Checks on the bookkeeping
  a_sense_first_pos: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_threshold_first |-> hcnt == 12'h024 && !o_normal_first)
    else $error("sense first pixel at wrong cycle");
  a_normal_first_pos: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_normal_first |-> hcnt == 12'h044 && $past(hcnt) == 12'h043)
    else $error("normal first pixel at wrong cycle");
  a_mult_first_pos: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_multiplied_first |-> hcnt == 12'h040)
    else $error("multiplied first pixel at wrong cycle");
  a_lag_one_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 !$past(split) |-> o_normal_line - o_multiplied_line == 16'h0001)
    else $error("multiplied lag not one line");
  a_lag_two_lines: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 $past(split) |-> o_normal_line - o_multiplied_line == 16'h0002)
    else $error("multiplied lag not two lines");
  a_step_wrap: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_mult_pass |-> o_mult_step == 11'h000 && $past(o_mult_step) == 11'h707)
    else $error("multiplying pass not at 1800 steps");
  a_line_len_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ls_rise && !split && o_normal_line != '0 && hcnt != 12'hc0c) |=> o_line_len_error)
    else $error("bad line length not flagged");
  a_split_len_ok: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ls_rise && split && hcnt == 12'h606 && !o_line_len_error) |=> !o_line_len_error)
    else $error("correct split line flagged");
  a_short_pixel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lg_fall && !ls_rise && gap < 8'h0c) |=> o_pixel_short)
    else $error("short pixel not flagged");
  a_barrier_order: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (b2_rise && !lvl[4]) |=> o_barrier_order_error)
    else $error("early barrier rise not flagged");
  a_barrier_fall: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s2_fall && lvl[3]) |=> o_barrier_order_error)
    else $error("late barrier fall not flagged");
  a_pixel_rate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (lg_fall && !ls_rise) |=> o_pixel_valid ##1 !o_pixel_valid)
    else $error("binned pixel not one per cycle");
endmodule // emccd_line_tracker

// *** hdl/pin_sync.sv ***
// Three-stage synchroniser with settle check for a group of pins.
// Assumes the pins are asynchronous to i_ref_clk.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1 // Number of pins
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] i_pin, // Raw pins
  output logic [WIDTH-1:0] o_level // Settled levels
);
  logic [WIDTH-1:0] s1, s2, s3; // Stages
  logic [WIDTH-1:0] next_level; // Settled value

  // Accept a bit only when the second and third stages agree
  always_comb begin
    next_level = o_level;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  // Stage registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_level <= '0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      o_level <= next_level;
    end
  end
endmodule // pin_sync

// *** verification/tb_top.sv ***
// Bench for the line tracker, with the timing generator model on its pins.
// Assumes a 250 MHz clock and the model's per-pixel timing of 13 clocks, 10 in the short-pixel check.
`timescale 1ns/100ps
module tb_top;
  import emccd_line_pkg::*;
  logic i_ref_clk = 1'b0; // Clock
  logic i_rst = 1'b1; // Reset
  logic i_split_mode; // Split line mode pin
  logic [1:0] i_bin_mode; // Binning pins
  logic split_sel = 1'b0; // Split mode wanted by the scenario
  logic [1:0] bin_sel = 2'h0; // Binning wanted by the scenario
  logic gate, lstart, barrier, storage; // Model pins
  logic ts_p, ng_p, mu_p, pv, pass, len_err, short, order_err; // Flags
  logic [LINE_W-1:0] nline, mline; // Line numbers
  logic [HCNT_W+1:0] col; // Column index
  logic [10:0] step; // Step index
  int fails = 0; // Mismatches
  int comparisons = 0; // Checks made
  int cycles = 0; // Timeout counter
  int ts_at, ng_at, mu_at, pv_n, pass_n; // Observed events
  // Clock
  always #2 i_ref_clk = ~i_ref_clk;
  // Mode pins follow the scenario's choice on the falling edge
  always @(negedge i_ref_clk) begin
    i_split_mode <= split_sel;
    i_bin_mode <= bin_sel;
  end
  timing_gen_model u_timing_gen_model (.i_ref_clk(i_ref_clk), .o_gate(gate),
    .o_line_start(lstart), .o_barrier(barrier), .o_storage(storage));
  emccd_line_tracker u_emccd_line_tracker (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_last_horizontal_gate_clock(gate), .i_line_start(lstart),
    .i_split_mode(i_split_mode), .i_mult_barrier_phase2(barrier),
    .i_mult_storage_phase2(storage), .i_bin_mode(i_bin_mode),
    .o_threshold_first(ts_p), .o_normal_first(ng_p), .o_multiplied_first(mu_p),
    .o_pixel_valid(pv), .o_normal_line(nline), .o_multiplied_line(mline),
    .o_column_index(col), .o_mult_step(step), .o_mult_pass(pass),
    .o_line_len_error(len_err), .o_pixel_short(short), .o_barrier_order_error(order_err));
  // Record pulse moments and counts; timeout guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (ts_p === 1'b1) ts_at = u_timing_gen_model.falls;
    if (ng_p === 1'b1) ng_at = u_timing_gen_model.falls;
    if (mu_p === 1'b1) mu_at = u_timing_gen_model.falls;
    if (pv === 1'b1) pv_n++;
    if (pass === 1'b1) pass_n++;
    if (cycles == 90000) begin
      fails++;
      test_done();
    end
  end
  // Count and report one comparison
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Reset for 4 cycles, then let pins settle
  task automatic reset_dut();
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    u_timing_gen_model.idle(4);
    i_rst = 1'b0;
    u_timing_gen_model.idle(8);
    pv_n = 0;
    pass_n = 0;
  endtask
  // First-pixel positions and one-line lag, whole line
  task automatic t_first();
    int want; // Packets that the threshold sends to normal gain
    reset_dut();
    u_timing_gen_model.start_line();
    u_timing_gen_model.pixels(70, 13);
    chk(ts_at == 36, "sense first pixel");
    chk(ng_at == 68, "normal first pixel");
    chk(mu_at == 64, "multiplied first pixel");
    chk(nline === 16'h0001 && mline === 16'h0000, "whole lag");
    // Packets 0..41 reach the switch 28 gate cycles after sensing
    want = 0;
    for (int k = 0; k < 42; k++) begin
      if ((k * 37) % 300 > 150) want++;
    end
    chk(u_timing_gen_model.routed_normal == want, "routing to normal gain");
  endtask
  // Each binning keeps one pixel per gate cycle
  task automatic t_bin();
    for (int b = 0; b < 4; b++) begin
      bin_sel = 2'(b);
      reset_dut();
      u_timing_gen_model.start_line();
      u_timing_gen_model.pixels(5, 13);
      u_timing_gen_model.idle(8);
      chk(col === 14'(5 * (b + 1)) && pv_n == 5, "binned columns");
    end
    bin_sel = 2'h0;
  endtask
  // Split lines: two-line lag, exact length, short line flagged
  task automatic t_split();
    split_sel = 1'b1;
    reset_dut();
    u_timing_gen_model.start_line();
    u_timing_gen_model.pixels(1542, 13);
    u_timing_gen_model.start_line();
    chk(nline === 16'h0002 && mline === 16'h0000, "split lag");
    u_timing_gen_model.pixels(1542, 13);
    u_timing_gen_model.start_line();
    chk(len_err === 1'b0, "exact line flagged");
    u_timing_gen_model.pixels(1541, 13);
    u_timing_gen_model.start_line();
    chk(len_err === 1'b1, "short line missed");
    split_sel = 1'b0;
  endtask
  // Pixel period at the limit passes, below it is flagged
  task automatic t_pixel();
    reset_dut();
    u_timing_gen_model.start_line();
    u_timing_gen_model.pixels(3, 13);
    chk(short === 1'b0, "legal pixel flagged");
    u_timing_gen_model.pixels(3, 10);
    u_timing_gen_model.idle(8);
    chk(short === 1'b1, "short pixel missed");
    // Second whole line after only 6 gate cycles: wrong length
    u_timing_gen_model.start_line();
    chk(len_err === 1'b1 && nline === 16'h0002, "short whole line missed");
  endtask
  // Full multiplying pass, then an out-of-order barrier
  task automatic t_mult();
    reset_dut();
    u_timing_gen_model.steps(1799, 1'b0);
    u_timing_gen_model.idle(8);
    chk(step === 11'h707 && pass_n == 0, "step before wrap");
    u_timing_gen_model.steps(1, 1'b0);
    u_timing_gen_model.idle(8);
    chk(step === 11'h000 && pass_n == 1, "pass at wrap");
    chk(order_err === 1'b0, "legal order flagged");
    u_timing_gen_model.steps(1, 1'b1);
    u_timing_gen_model.idle(8);
    chk(order_err === 1'b1, "bad order missed");
    reset_dut();
    u_timing_gen_model.late_fall();
    u_timing_gen_model.idle(8);
    chk(order_err === 1'b1, "late barrier fall missed");
  endtask
  // Counts and verdict
  task automatic test_done();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_first();
    t_bin();
    t_pixel();
    t_mult();
    t_split();
    test_done();
  end
endmodule // tb_top

// *** verification/timing_gen_model.sv ***
// Camera timing generator model: drives the readout clock pins.
// Assumes the bench calls its tasks; pins change on falling clock edges.
`timescale 1ns/100ps
module timing_gen_model (
  input wire logic i_ref_clk, // System clock
  output logic o_gate, // Last gate clock pin
  output logic o_line_start, // Line start pin
  output logic o_barrier, // Second barrier clock pin
  output logic o_storage // Second storage clock pin
);
  int falls; // Gate falls since line start
  localparam int ROUTE_DELAY = 28; // Gate cycles from sensing to the charge switch
  localparam int ROUTE_LIMIT = 150; // Electrons; larger packets go to normal gain
  localparam int CLAMP_CYCLES = 28; // Clamp window at line start
  logic [ROUTE_DELAY-1:0] route_q; // Route bits on their way to the switch
  logic sw_normal; // Charge-switch clock toward normal gain
  logic sw_multiply; // Charge-switch clock toward the multiplier
  logic clamp; // Front-end black level clamp
  int routed_normal; // Packets sent to the normal output this line
  // Stand-in for the digitised threshold-sense sample, in electrons
  function automatic int sense(input int k);
    return (k * 37) % 300;
  endfunction
  // Parked levels: second-phase gates low
  initial begin
    o_gate = 1'b0;
    o_line_start = 1'b0;
    o_barrier = 1'b0;
    o_storage = 1'b0;
    falls = 0;
    route_q = '0;
    sw_normal = 1'b0;
    sw_multiply = 1'b0;
    clamp = 1'b0;
    routed_normal = 0;
  end
  // Let n falling edges pass
  task automatic idle(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // Row transfer done, gates parked, line begins
  task automatic start_line();
    o_line_start = 1'b1;
    falls = 0;
    route_q = '0;
    routed_normal = 0;
    idle(4);
    o_line_start = 1'b0;
    idle(4);
  endtask
  // n pixels of per clocks; caller sets line length
  task automatic pixels(input int n, input int per);
    repeat (n) begin
      clamp = (falls < CLAMP_CYCLES);
      sw_normal = route_q[ROUTE_DELAY-1];
      sw_multiply = !route_q[ROUTE_DELAY-1];
      o_gate = 1'b1;
      idle(per / 2);
      if (sw_normal) begin
        routed_normal++;
      end
      sw_normal = 1'b0;
      sw_multiply = 1'b0;
      // Packet sensed on this gate fall; its route waits in the queue
      route_q = {route_q[ROUTE_DELAY-2:0], sense(falls) > ROUTE_LIMIT};
      o_gate = 1'b0;
      falls++;
      idle(per - per / 2);
    end
  endtask
  // Multiplying steps; bad raises barrier with storage low
  task automatic steps(input int n, input bit bad);
    repeat (n) begin
      o_storage = !bad;
      idle(2);
      o_barrier = 1'b1;
      idle(2);
      o_barrier = 1'b0;
      idle(2);
      o_storage = 1'b0;
      idle(2);
    end
  endtask
  // One step whose storage falls while the barrier is still high
  task automatic late_fall();
    o_storage = 1'b1;
    idle(2);
    o_barrier = 1'b1;
    idle(2);
    o_storage = 1'b0;
    idle(2);
    o_barrier = 1'b0;
    idle(2);
  endtask
endmodule // timing_gen_model
